// ===== rtl/serial_link_pkg.sv
// Constants for the serial link control and lane test pattern block
package serial_link_pkg;
  // Register offsets and reset values
  localparam logic [15:0] FRAMING_CTRL_ADDR = 16'h0060;
  localparam logic [15:0] SYNC_TEST_CTRL_ADDR = 16'h0061;
  localparam logic [7:0] FRAMING_CTRL_RESET = 8'h7d;
  localparam logic [7:0] SYNC_TEST_CTRL_RESET = 8'h00;
  // Field positions
  localparam int SCRAMBLE_ON_BIT = 7;
  localparam int FPMF_MSB = 6;
  localparam int FPMF_LSB = 2;
  localparam int LINK_ON_BIT = 0;
  localparam int SYNC_SOURCE_BIT = 7;
  localparam int SOFT_SYNC_BIT = 6;
  localparam int TEST_MSB = 3;
  localparam int TEST_LSB = 0;
  // Test pattern codes
  localparam logic [3:0] TP_NORMAL = 4'h0;
  localparam logic [3:0] TP_PRBS7 = 4'h1;
  localparam logic [3:0] TP_PRBS15 = 4'h2;
  localparam logic [3:0] TP_PRBS23 = 4'h3;
  localparam logic [3:0] TP_ILA = 4'h5;
  localparam logic [3:0] TP_RAMP = 4'h6;
  localparam logic [3:0] TP_K285 = 4'h7;
  localparam logic [3:0] TP_D215 = 4'h8;
  localparam logic [3:0] TP_LOW = 4'h9;
  localparam logic [3:0] TP_HIGH = 4'ha;
  // Lane symbols: bit 8 marks a control character
  localparam logic [9:0] SYM_K285 = 10'h01bc;
  localparam logic [9:0] SYM_K280 = 10'h011c;
  localparam logic [9:0] SYM_K283 = 10'h017c;
  localparam logic [9:0] SYM_K284 = 10'h019c;
  localparam logic [9:0] SYM_D215 = 10'h00b5;
  localparam logic [9:0] RAW_ALTERNATE = 10'h0155;
  localparam logic [9:0] RAW_LOW = 10'h0000;
  localparam logic [9:0] RAW_HIGH = 10'h03ff;
  localparam logic [22:0] PRBS_SEED = 23'h7f_ffff;
  // Timing counts: sync hold in frame clock periods, last ILA multiframe index
  localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4;
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  typedef enum logic [1:0] {ST_OFF, ST_CGS, ST_ILA, ST_DATA} link_state_e;
endpackage

// ===== rtl/serial_link_control.sv
// Link enable, framing, sync source and lane test pattern control
`timescale 1ns/100ps
// How it works
// - Scramble data octets when scramble bit set
// - Field holds K minus one, reset 31
// - Link on: synchronize, then send samples
// - Link off: send alternating 0101 bits
// - Sync source bit picks pin or soft
// - Soft sync bit zero requests synchronization
// - Soft sync bit ignored when pins selected
// - Codes 0-3 select normal or PRBS
// - Codes 5-8 select ILA, ramp, K28.5, D21.5
// - Codes 9 and 10 hold lane low/high
module serial_link_control
  import serial_link_pkg::*;
(
  input wire logic clk, // Frame clock
  input wire logic rst_n, // Async reset, active low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  output logic reg_rvalid, // Read data valid
  input wire logic syncb_pin_n, // SYNCb from receiver pins
  input wire logic [7:0] sample_octet, // Converter octet, one per frame
  output logic [9:0] tx_sym, // Lane symbol or raw line bits
  output logic tx_raw, // tx_sym holds raw line bits
  output logic sync_request_n, // Internal SYNCb, low requests sync
  output logic link_up // Valid data being sent
);
  logic [7:0] framing_ctrl;
  logic [7:0] sync_test_ctrl;
  logic syncb_s1, syncb_s2;
  link_state_e state;
  logic [4:0] lmfc_cnt;
  logic [1:0] ila_mf;
  logic [2:0] req_cnt;
  logic sync_armed;
  logic [14:0] scr_state;
  logic [22:0] prbs;
  logic [7:0] ramp;
  logic [9:0] next_sym;
  logic next_raw;
  logic [7:0] scr_out;
  logic [14:0] next_scr;
  logic [22:0] next_prbs;
  logic [9:0] prbs_bits;
  logic [9:0] ila_sym;

  wire logic link_on = framing_ctrl[LINK_ON_BIT];
  wire logic scramble_on = framing_ctrl[SCRAMBLE_ON_BIT];
  wire logic [4:0] frames_per_multiframe_minus_one = framing_ctrl[FPMF_MSB:FPMF_LSB];
  wire logic sync_source = sync_test_ctrl[SYNC_SOURCE_BIT];
  wire logic soft_sync_request_n = sync_test_ctrl[SOFT_SYNC_BIT];
  wire logic [3:0] lane_test_pattern_select = sync_test_ctrl[TEST_MSB:TEST_LSB];
  wire logic lmfc_end = (lmfc_cnt >= frames_per_multiframe_minus_one);
  wire logic sending_data = link_on && (state == ST_DATA)
                            && (lane_test_pattern_select == TP_NORMAL);

  // Register writes; all bits are stored as written and read back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      framing_ctrl <= FRAMING_CTRL_RESET;
      sync_test_ctrl <= SYNC_TEST_CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == FRAMING_CTRL_ADDR) begin
        framing_ctrl <= reg_wdata;
      end
      if (reg_addr == SYNC_TEST_CTRL_ADDR) begin
        sync_test_ctrl <= reg_wdata;
      end
    end
  end

  // Register reads, answered one cycle later, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == FRAMING_CTRL_ADDR) begin
        reg_rdata <= framing_ctrl;
      end else if (reg_addr == SYNC_TEST_CTRL_ADDR) begin
        reg_rdata <= sync_test_ctrl;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Two-flop synchroniser on the SYNCb pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncb_s1 <= 1'b1;
      syncb_s2 <= 1'b1;
    end else begin
      syncb_s1 <= syncb_pin_n;
      syncb_s2 <= syncb_s1;
    end
  end

  // Internal SYNCb source select; soft bit unused when pins chosen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_request_n <= 1'b1;
    end else begin
      sync_request_n <= sync_source ? soft_sync_request_n : syncb_s2;
    end
  end

  // Count how long a sync request has been held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_cnt <= 3'h0;
      sync_armed <= 1'b0;
    end else begin
      if (sync_request_n) begin
        req_cnt <= 3'h0;
      end else if (req_cnt != SYNC_MIN_FRAMES) begin
        req_cnt <= req_cnt + 3'h1;
      end
      // Drop the request while the link is off and once it has started ILA,
      // so a stale request cannot restart the sequence later
      if (!link_on || (state == ST_CGS && sync_armed && sync_request_n && lmfc_end)) begin
        sync_armed <= 1'b0;
      end else if (req_cnt == SYNC_MIN_FRAMES) begin
        sync_armed <= 1'b1;
      end
    end
  end

  // Local multiframe counter, K frames long, and ILA multiframe count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_cnt <= 5'h00;
      ila_mf <= 2'h0;
    end else begin
      lmfc_cnt <= lmfc_end ? 5'h00 : lmfc_cnt + 5'h01;
      if (state != ST_ILA && lane_test_pattern_select != TP_ILA) begin
        ila_mf <= 2'h0;
      end else if (lmfc_end) begin
        ila_mf <= ila_mf + 2'h1;
      end
    end
  end

  // Link sequence: code groups, ILA, then data; a held request restarts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OFF;
    end else if (!link_on) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_OFF: state <= ST_CGS;
        ST_CGS: begin
          if (sync_armed && sync_request_n && lmfc_end) begin
            state <= ST_ILA;
          end
        end
        ST_ILA: begin
          if (sync_armed) begin
            state <= ST_CGS;
          end else if (lmfc_end && ila_mf == ILA_LAST_MF) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (sync_armed) begin
            state <= ST_CGS;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // Self-synchronous scrambler 1 + x^14 + x^15, octet msb first
  always_comb begin
    next_scr = scr_state;
    scr_out = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      scr_out[i] = sample_octet[i] ^ next_scr[14] ^ next_scr[13];
      next_scr = {next_scr[13:0], scr_out[i]};
    end
  end

  // PRBS generator, ten line bits per frame, taps by selected order
  // Short orders use the low bits of the shared register, which a longer
  // pattern may leave all zero; a one is forced in then to escape lockup
  always_comb begin
    next_prbs = prbs;
    prbs_bits = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      case (lane_test_pattern_select)
        TP_PRBS7: prbs_bits[i] = (next_prbs[6] ^ next_prbs[5])
                                 | (next_prbs[6:0] == 7'h00);
        TP_PRBS15: prbs_bits[i] = (next_prbs[14] ^ next_prbs[13])
                                  | (next_prbs[14:0] == 15'h0000);
        default: prbs_bits[i] = next_prbs[22] ^ next_prbs[17];
      endcase
      next_prbs = {next_prbs[21:0], prbs_bits[i]};
    end
  end

  // Pattern generator state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scr_state <= 15'h7fff;
      prbs <= PRBS_SEED;
      ramp <= 8'h00;
    end else begin
      if (sending_data && scramble_on) begin
        scr_state <= next_scr;
      end
      prbs <= next_prbs;
      ramp <= ramp + 8'h01;
    end
  end

  // ILA multiframe content: start, lane-setup marker, end
  always_comb begin
    if (lmfc_cnt == 5'h00) begin
      ila_sym = SYM_K280;
    end else if (lmfc_end) begin
      ila_sym = SYM_K283;
    end else if (ila_mf == 2'h1 && lmfc_cnt == 5'h01) begin
      ila_sym = SYM_K284;
    end else begin
      ila_sym = {5'h00, lmfc_cnt};
    end
  end

  // Lane output select
  always_comb begin
    next_raw = 1'b0;
    next_sym = SYM_K285;
    if (!link_on) begin
      next_raw = 1'b1;
      next_sym = RAW_ALTERNATE;
    end else begin
      case (lane_test_pattern_select)
        TP_PRBS7, TP_PRBS15, TP_PRBS23: begin
          next_raw = 1'b1;
          next_sym = prbs_bits;
        end
        TP_ILA: next_sym = ila_sym;
        TP_RAMP: next_sym = {2'b00, ramp};
        TP_K285: next_sym = SYM_K285;
        TP_D215: next_sym = SYM_D215;
        TP_LOW: begin
          next_raw = 1'b1;
          next_sym = RAW_LOW;
        end
        TP_HIGH: begin
          next_raw = 1'b1;
          next_sym = RAW_HIGH;
        end
        default: begin
          case (state)
            ST_ILA: next_sym = ila_sym;
            ST_DATA: next_sym = {2'b00, scramble_on ? scr_out : sample_octet};
            default: next_sym = SYM_K285;
          endcase
        end
      endcase
    end
  end

  // Registered lane outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sym <= RAW_ALTERNATE;
      tx_raw <= 1'b1;
      link_up <= 1'b0;
    end else begin
      tx_sym <= next_sym;
      tx_raw <= next_raw;
      link_up <= sending_data;
    end
  end

  // Checks
  chk_plain_data: assert property (@(posedge clk) disable iff (!rst_n)
    sending_data && !scramble_on |=> tx_sym == {2'b00, $past(sample_octet)} && !tx_raw)
    else $error("plain data octet not passed");
  chk_scrambled_data: assert property (@(posedge clk) disable iff (!rst_n)
    sending_data && scramble_on |=> tx_sym[7:0] == scr_state[7:0])
    else $error("scrambled octet does not match scrambler history");
  chk_multiframe_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    lmfc_cnt == frames_per_multiframe_minus_one |=> lmfc_cnt == 5'h00)
    else $error("multiframe counter did not wrap at K");
  chk_link_off_pattern: assert property (@(posedge clk) disable iff (!rst_n)
    !link_on |=> tx_raw && tx_sym == RAW_ALTERNATE)
    else $error("disabled link not sending alternating bits");
  chk_pin_sync_path: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_source |=> sync_request_n == $past(syncb_s2))
    else $error("pin sync not routed");
  chk_soft_sync_path: assert property (@(posedge clk) disable iff (!rst_n)
    sync_source |=> sync_request_n == $past(soft_sync_request_n))
    else $error("soft sync not routed");
  chk_soft_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_source ##1 !sync_source && $stable(syncb_s2) ##1 !sync_source
    |-> $stable(sync_request_n))
    else $error("soft sync bit leaked through");
  chk_k285_stream: assert property (@(posedge clk) disable iff (!rst_n)
    link_on && lane_test_pattern_select == TP_K285 |=> tx_sym == SYM_K285 && !tx_raw)
    else $error("K28.5 pattern wrong");
  chk_level_patterns: assert property (@(posedge clk) disable iff (!rst_n)
    link_on && lane_test_pattern_select == TP_LOW ##1
    link_on && lane_test_pattern_select == TP_LOW |-> tx_raw && tx_sym == RAW_LOW ##1
    tx_sym == RAW_LOW)
    else $error("logic low pattern not held");
  chk_data_after_ila: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(link_up) |-> $past(state, 2) == ST_ILA)
    else $error("data began without ILA");
  cov_reach_data: cover property (@(posedge clk) disable iff (!rst_n) $rose(link_up));
  cov_ila_start: cover property (@(posedge clk) disable iff (!rst_n)
    state == ST_CGS ##1 state == ST_ILA);
  cov_prbs_mode: cover property (@(posedge clk) disable iff (!rst_n)
    link_on && lane_test_pattern_select == TP_PRBS23 ##1 tx_raw);
  cov_soft_sync: cover property (@(posedge clk) disable iff (!rst_n)
    sync_source && !sync_request_n ##1 sync_request_n);
endmodule

// ===== dv/sync_rx_model.sv
// Receiver-side model that drives the SYNCb pins
`timescale 1ns/100ps
module sync_rx_model (
  input wire logic clk, // Frame clock
  input wire logic rst_n, // Async reset, active low
  input wire logic req, // Bench asks for a sync request
  input wire logic glitch, // Bench asks for a too-short request
  output logic syncb_pin_n // SYNCb to the device, low requests
);
  logic [2:0] held;
  // Count frames of a request so it stays low for at least four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 3'h0;
    end else if (req || (held != 3'h0 && held < 3'h4)) begin
      held <= (held == 3'h4) ? held : held + 3'h1;
    end else begin
      held <= 3'h0;
    end
  end
  // Glitch bypasses the minimum hold on purpose
  assign syncb_pin_n = !(req || glitch || (held != 3'h0 && held < 3'h4));
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the serial link control block
`timescale 1ns/100ps
module tb_top;
  import serial_link_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] sample_octet = 8'h00;
  logic req = 1'b0;
  logic glitch = 1'b0;
  logic syncb_pin_n, reg_rvalid, tx_raw, sync_request_n, link_up, hit;
  logic [7:0] reg_rdata, v;
  logic [9:0] tx_sym, prev;
  logic [23:0] hist = 24'h00_0000;
  logic [7:0] sync_cfg [4] = '{8'h80, 8'hc0, 8'h40, 8'h00};
  logic sync_req [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic sync_exp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  integer seed = 32'hd137;
  int n_errors = 0;
  int checked = 0;
  int waited;
  // Free-running frame clock
  always #2 clk = ~clk;
  serial_link_control dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .syncb_pin_n(syncb_pin_n), .sample_octet(sample_octet),
    .tx_sym(tx_sym), .tx_raw(tx_raw), .sync_request_n(sync_request_n), .link_up(link_up));
  sync_rx_model rx (.clk(clk), .rst_n(rst_n), .req(req), .glitch(glitch),
    .syncb_pin_n(syncb_pin_n));
  // Compare and count
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Step n edges, then settle past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Register write, one-cycle strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  // Register read, answer checked just after the edge that samples the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    check({2'b00, reg_rvalid, reg_rdata}, {3'b001, exp});
    tick(1);
  endtask
  // Expected lane output for fixed test codes, pins idle so normal stays in CGS
  function automatic logic [10:0] tp_exp(input int c);
    case (c)
      8: return {1'b0, SYM_D215};
      9: return {1'b1, RAW_LOW};
      10: return {1'b1, RAW_HIGH};
      default: return {1'b0, SYM_K285};
    endcase
  endfunction
  // Undo the self-synchronous scrambler on the newest of three octets, msb first
  function automatic logic [7:0] descramble(input logic [23:0] h);
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d[i] = h[i] ^ h[i + 14] ^ h[i + 15];
    end
    return d;
  endfunction
  // Bring the link up with a random K, then check data or scrambling
  task automatic link_run(input logic scr);
    logic [4:0] kf;
    int k;
    kf = 5'h08 + 5'({$random(seed)} % 24);
    k = int'(kf) + 1;
    wr(16'h0060, {scr, kf, 2'b00});
    wr(16'h0061, 8'h00);
    wr(16'h0060, {scr, kf, 2'b01});
    req = 1'b1;
    tick(2);
    req = 1'b0;
    waited = 0;
    while (link_up !== 1'b1 && waited < 400) begin
      tick(1);
      waited++;
    end
    if (waited >= 400) begin
      n_errors++;
      return;
    end
    check({10'h000, waited >= 4 * k && waited <= 5 * k + 12}, 11'h001);
    v = 8'($random(seed));
    sample_octet = v;
    tick(3);
    repeat (3) begin
      hist = {hist[15:0], tx_sym[7:0]};
      tick(1);
    end
    if (!scr) begin
      check({tx_raw, tx_sym}, {3'b000, v});
    end else begin
      check({3'b000, descramble(hist)}, {3'b000, v});
    end
  endtask
  // Main sequence
  initial begin
    tick(10);
    rst_n = 1'b1;
    tick(1);
    rd(16'h0060, 8'h7d);
    rd(16'h0061, 8'h00);
    rd(16'h0062, 8'h00);
    check({tx_raw, tx_sym}, {1'b0, SYM_K285});
    wr(16'h0060, 8'h7c);
    repeat (3) begin
      v = 8'($random(seed));
      wr(16'h0061, v);
      rd(16'h0061, v);
    end
    for (int c = 0; c < 16; c++) begin
      wr(16'h0061, 8'(c));
      wr(16'h0060, 8'h7d);
      tick(3);
      prev = tx_sym;
      tick(1);
      if (c >= 1 && c <= 3) begin
        check({10'h000, prev != tx_sym}, 11'h001);
      end else if (c == 6) begin
        check({2'b00, tx_raw, tx_sym[7:0]}, {3'b000, prev[7:0] + 8'h01});
      end else if (c == 5) begin
        hit = 1'b0;
        repeat (40) begin
          hit = hit | (tx_sym === SYM_K280);
          tick(1);
        end
        check({10'h000, hit}, 11'h001);
      end else begin
        check({tx_raw, tx_sym}, tp_exp(c));
      end
      wr(16'h0060, 8'h7c);
    end
    wr(16'h0061, 8'h07);
    tick(2);
    check({tx_raw, tx_sym}, {1'b1, RAW_ALTERNATE});
    for (int i = 0; i < 4; i++) begin
      wr(16'h0061, sync_cfg[i]);
      req = sync_req[i];
      tick(8);
      check({10'h000, sync_request_n}, {10'h000, sync_exp[i]});
    end
    wr(16'h0060, 8'h7d);
    glitch = 1'b1;
    tick(2);
    glitch = 1'b0;
    tick(40);
    check({tx_raw, tx_sym}, {1'b0, SYM_K285});
    link_run(1'b0);
    link_run(1'b1);
    complete_run();
  end
endmodule
